// file: design/tci_interp.sv
// serial command interpreter for one terminal or modem port
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// [RULE1] A, optional digit 1-6: present status
// [RULE2] no digit selects system control cabinet
// [RULE3] control-B: event history, newest first
// [RULE4] C: history status, newest first
// [RULE5] F toggles output freeze, no return
// [RULE6] G clears and unfreezes history buffer
// [RULE7] Q quits output, returns to idle
// [RULE8] d mm/dd/yy loads clock date
// [RULE9] t hh:mm:ss loads clock time
// [RULE10] H hangs up, modem port only
// [RULE11] I J K L: discharge duration bands
// [RULE12] M: discharge summary screen
// [RULE13] N: all discharge details, newest first
// [RULE14] backspace drops last typed character
// [RULE15] one instance per port, all concurrent
// [RULE16] 8N1 async, 2400 or 1200 baud
// [RULE17] either case except lowercase d, t
// [RULE18] greeting sent on modem connect
// [RULE19] local port: status on new alarm
// [RULE20] bad input discarded, nothing altered
module tci_interp
    import tci_pkg::*;
#(
    parameter logic        IS_MODEM   = 1'b1, // RULE15
    parameter logic [15:0] BIT_CYCLES = 16'(BIT_CYC)
) (
    input  wire logic       clk_sys_in,
    input  wire logic       rst_in,
    input  wire logic       rx_in,
    output logic            tx_out,
    input  wire logic       baud_slow_in,
    input  wire logic       modem_connect_in,
    input  wire logic       alarm_new_in,
    input  wire logic [7:0] rpt_data_in,
    input  wire logic       rpt_valid_in,
    output logic            rpt_ready_out,
    input  wire logic       rpt_done_in,
    output logic            rpt_start_out,
    output logic            rpt_abort_out,
    output logic [3:0]      rpt_kind_out,
    output logic [2:0]      rpt_module_out,
    output logic            hist_reset_out,
    output logic            hangup_out,
    output logic            date_load_out,
    output logic [7:0]      date_month_out,
    output logic [7:0]      date_day_out,
    output logic [7:0]      date_year_out,
    output logic            time_load_out,
    output logic [7:0]      time_hour_out,
    output logic [7:0]      time_min_out,
    output logic [7:0]      time_sec_out,
    output logic            freeze_out,
    output logic            busy_out
);
    function automatic logic [7:0] upcase(input logic [7:0] c);
        upcase = (c >= CH_LO_A && c <= CH_LO_Z) ? (c & CH_CASE) : c;
    endfunction : upcase

    function automatic logic is_dig(input logic [7:0] c);
        is_dig = (c >= CH_ZERO) && (c <= CH_NINE);
    endfunction : is_dig

    logic [16:0] bit_len;
    // 1200 baud is exactly twice the 2400 baud bit time
    assign bit_len = baud_slow_in ? {BIT_CYCLES, 1'b0} : {1'b0, BIT_CYCLES}; // RULE16

    // ---------------- receiver ----------------
    logic        rx_busy_reg, rx_busy_next;
    logic [16:0] rx_cnt_reg, rx_cnt_next;
    logic [3:0]  rx_bit_reg, rx_bit_next;
    logic [7:0]  rx_sh_reg, rx_sh_next;
    logic        rx_stb_reg, rx_stb_next;

    always_comb begin
        rx_busy_next = rx_busy_reg;
        rx_cnt_next  = rx_cnt_reg;
        rx_bit_next  = rx_bit_reg;
        rx_sh_next   = rx_sh_reg;
        rx_stb_next  = 1'b0;
        if (!rx_busy_reg) begin
            if (!rx_in) begin
                rx_busy_next = 1'b1;
                rx_cnt_next  = bit_len >> 1;
                rx_bit_next  = 4'h0;
            end
        end else if (rx_cnt_reg != 17'h0) begin
            rx_cnt_next = rx_cnt_reg - 17'h1;
        end else begin
            rx_cnt_next = bit_len - 17'h1;
            if (rx_bit_reg == 4'h0) begin
                rx_busy_next = !rx_in;
                rx_bit_next  = 4'h1;
            end else if (rx_bit_reg <= 4'h8) begin
                rx_sh_next  = {rx_in, rx_sh_reg[7:1]};
                rx_bit_next = rx_bit_reg + 4'h1;
            end else begin
                // framing error: a low stop bit drops the byte
                rx_busy_next = 1'b0;
                rx_stb_next  = rx_in; // RULE16 RULE20
            end
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            rx_busy_reg <= 1'b0;
            rx_cnt_reg  <= 17'h0;
            rx_bit_reg  <= 4'h0;
            rx_sh_reg   <= 8'h00;
            rx_stb_reg  <= 1'b0;
        end else begin
            rx_busy_reg <= rx_busy_next;
            rx_cnt_reg  <= rx_cnt_next;
            rx_bit_reg  <= rx_bit_next;
            rx_sh_reg   <= rx_sh_next;
            rx_stb_reg  <= rx_stb_next;
        end
    end

    // ---------------- transmitter ----------------
    logic        buf_valid;
    logic [7:0]  buf_data;
    logic        tx_take;
    logic        tx_busy_reg, tx_busy_next;
    logic [16:0] tx_cnt_reg, tx_cnt_next;
    logic [3:0]  tx_bit_reg, tx_bit_next;
    logic [8:0]  tx_sh_reg, tx_sh_next;
    logic        tx_line_reg, tx_line_next;
    logic        freeze_reg, freeze_next;
    logic        flush;

    // a frozen port stalls here, the buffer fills, the source waits
    assign tx_take = buf_valid && !tx_busy_reg && !freeze_reg; // RULE5

    always_comb begin
        tx_busy_next = tx_busy_reg;
        tx_cnt_next  = tx_cnt_reg;
        tx_bit_next  = tx_bit_reg;
        tx_sh_next   = tx_sh_reg;
        tx_line_next = tx_line_reg;
        if (tx_take) begin
            tx_busy_next = 1'b1;
            tx_line_next = 1'b0; // RULE16
            tx_sh_next   = {1'b1, buf_data};
            tx_bit_next  = 4'h0;
            tx_cnt_next  = bit_len - 17'h1;
        end else if (tx_busy_reg) begin
            if (tx_cnt_reg != 17'h0) begin
                tx_cnt_next = tx_cnt_reg - 17'h1;
            end else if (tx_bit_reg == 4'h9) begin
                tx_busy_next = 1'b0;
            end else begin
                tx_line_next = tx_sh_reg[0];
                tx_sh_next   = {1'b1, tx_sh_reg[8:1]};
                tx_bit_next  = tx_bit_reg + 4'h1;
                tx_cnt_next  = bit_len - 17'h1;
            end
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            tx_busy_reg <= 1'b0;
            tx_cnt_reg  <= 17'h0;
            tx_bit_reg  <= 4'h0;
            tx_sh_reg   <= 9'h1FF;
            tx_line_reg <= 1'b1;
        end else begin
            tx_busy_reg <= tx_busy_next;
            tx_cnt_reg  <= tx_cnt_next;
            tx_bit_reg  <= tx_bit_next;
            tx_sh_reg   <= tx_sh_next;
            tx_line_reg <= tx_line_next;
        end
    end

    tci_skid #(.W(8)) u_skid (
        .clk_sys_in   (clk_sys_in),
        .rst_in       (rst_in),
        .flush_in     (flush),
        .in_data_in   (rpt_data_in),
        .in_valid_in  (rpt_valid_in),
        .in_ready_out (rpt_ready_out),
        .out_data_out (buf_data),
        .out_valid_out(buf_valid),
        .out_ready_in (tx_take)
    );

    // ---------------- command parser ----------------
    tci_state_t  st_reg, st_next;
    logic [7:0]  line_mem [LEN_MAX];
    logic [3:0]  len_reg, len_next;
    logic        ovf_reg, ovf_next;
    logic        line_wr;
    logic        conn_d_reg;
    logic        greet_reg, greet_next;
    logic        alarm_reg, alarm_next;
    logic        start_next, abort_next, hist_next, hang_next;
    logic        dload_next, tload_next;
    logic [3:0]  kind_reg, kind_next;
    logic [2:0]  mod_reg, mod_next;
    logic [7:0]  ch, c0, f0, f1, f2;
    logic        rpt_ok, mod_ok, field_ok, is_cr;
    logic        rpt_start_reg, rpt_abort_reg, hist_reg, hang_reg;
    logic        dload_reg, tload_reg;
    logic [7:0]  fa_reg, fb_reg, fc_reg;

    assign ch  = rx_sh_reg;
    assign c0  = line_mem[0];
    assign f0  = {line_mem[2][3:0], line_mem[3][3:0]};
    assign f1  = {line_mem[5][3:0], line_mem[6][3:0]};
    assign f2  = {line_mem[8][3:0], line_mem[9][3:0]};
    assign is_cr = rx_stb_reg && (ch == CH_CR) && !ovf_reg;
    assign mod_ok = (len_reg == 4'h2) && line_mem[1] >= CH_ONE
                    && line_mem[1] <= CH_SIX; // RULE1
    assign rpt_ok = (len_reg == 4'h1) || mod_ok;
    assign field_ok = (len_reg == LEN_MAX) && line_mem[1] == CH_SPACE
                      && is_dig(line_mem[2]) && is_dig(line_mem[3])
                      && is_dig(line_mem[5]) && is_dig(line_mem[6])
                      && is_dig(line_mem[8]) && is_dig(line_mem[9]);
    assign line_wr = rx_stb_reg && (ch != CH_CR) && (ch != CH_BS)
                     && (ch != CH_DEL) && upcase(ch) != CH_F
                     && upcase(ch) != CH_Q && len_reg < LEN_MAX;
    assign flush = rx_stb_reg && upcase(ch) == CH_Q; // RULE7

    always_comb begin
        st_next    = st_reg;
        freeze_next = freeze_reg;
        len_next   = len_reg;
        ovf_next   = ovf_reg;
        greet_next = greet_reg | (IS_MODEM & modem_connect_in & !conn_d_reg);
        alarm_next = alarm_reg | (!IS_MODEM & alarm_new_in); // RULE19
        start_next = 1'b0;
        abort_next = 1'b0;
        hist_next  = 1'b0;
        hang_next  = 1'b0;
        dload_next = 1'b0;
        tload_next = 1'b0;
        kind_next  = kind_reg;
        mod_next   = MOD_CABINET; // RULE2
        if (st_reg == ST_RUN && rpt_done_in) begin
            st_next = ST_IDLE;
        end
        if (rx_stb_reg) begin
            if (upcase(ch) == CH_F) begin
                freeze_next = !freeze_reg; // RULE5
            end else if (upcase(ch) == CH_Q) begin
                abort_next = (st_reg == ST_RUN); // RULE7
                st_next    = ST_IDLE;
                len_next   = 4'h0;
                ovf_next   = 1'b0;
            end else if (ch == CH_BS || ch == CH_DEL) begin
                if (len_reg != 4'h0) begin
                    len_next = len_reg - 4'h1; // RULE14
                end
            end else if (ch == CH_CR) begin
                len_next = 4'h0;
                ovf_next = 1'b0;
            end else if (len_reg == LEN_MAX) begin
                ovf_next = 1'b1; // RULE20
            end else begin
                len_next = len_reg + 4'h1;
            end
        end
        if (is_cr) begin
            if (mod_ok) begin
                mod_next = line_mem[1][2:0]; // RULE1
            end
            start_next = (st_reg == ST_IDLE);
            unique case (1'b1)
                rpt_ok && upcase(c0) == CH_A: kind_next = RPT_STATUS; // RULE1
                rpt_ok && c0 == CH_CTLB:      kind_next = RPT_EVENT; // RULE3
                rpt_ok && (upcase(c0) == CH_C || c0 == CH_CTLC):
                    kind_next = RPT_HIST; // RULE4
                len_reg == 4'h1 && upcase(c0) == CH_I: kind_next = RPT_BAND0;
                len_reg == 4'h1 && upcase(c0) == CH_J: kind_next = RPT_BAND1;
                len_reg == 4'h1 && upcase(c0) == CH_K: kind_next = RPT_BAND2;
                len_reg == 4'h1 && upcase(c0) == CH_L:
                    kind_next = RPT_BAND3; // RULE11
                len_reg == 4'h1 && upcase(c0) == CH_M:
                    kind_next = RPT_SUMM; // RULE12
                len_reg == 4'h1 && upcase(c0) == CH_N:
                    kind_next = RPT_DETAIL; // RULE13
                default: begin
                    start_next = 1'b0;
                    hist_next  = len_reg == 4'h1 && upcase(c0) == CH_G; // RULE6
                    hang_next  = IS_MODEM && len_reg == 4'h1
                                 && upcase(c0) == CH_H; // RULE10
                    // lowercase only for the clock setters
                    dload_next = field_ok && c0 == CH_LO_D
                                 && line_mem[4] == CH_SLASH
                                 && line_mem[7] == CH_SLASH
                                 && f0 != 8'h00 && f0 <= BCD_MON
                                 && f1 != 8'h00 && f1 <= BCD_DAY; // RULE8 RULE17
                    tload_next = field_ok && c0 == CH_LO_T
                                 && line_mem[4] == CH_COLON
                                 && line_mem[7] == CH_COLON
                                 && f0 <= BCD_HOUR && f1 <= BCD_MIN
                                 && f2 <= BCD_MIN; // RULE9 RULE17
                end
            endcase
        end
        // greeting first, then alarm report, only while idle
        if (!start_next && st_next == ST_IDLE && !flush) begin
            if (greet_reg) begin
                start_next = 1'b1;
                kind_next  = RPT_GREET; // RULE18
                greet_next = IS_MODEM & modem_connect_in & !conn_d_reg;
            end else if (alarm_reg) begin
                start_next = 1'b1;
                kind_next  = RPT_STATUS; // RULE19
                alarm_next = !IS_MODEM & alarm_new_in;
            end
        end
        if (!start_next) begin
            kind_next = kind_reg;
        end
        if (start_next) begin
            st_next = ST_RUN;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            st_reg        <= ST_IDLE;
            freeze_reg    <= 1'b0;
            len_reg       <= 4'h0;
            ovf_reg       <= 1'b0;
            conn_d_reg    <= 1'b0;
            greet_reg     <= 1'b0;
            alarm_reg     <= 1'b0;
            rpt_start_reg <= 1'b0;
            rpt_abort_reg <= 1'b0;
            hist_reg      <= 1'b0;
            hang_reg      <= 1'b0;
            dload_reg     <= 1'b0;
            tload_reg     <= 1'b0;
            kind_reg      <= RPT_STATUS;
            mod_reg       <= MOD_CABINET;
            fa_reg        <= 8'h00;
            fb_reg        <= 8'h00;
            fc_reg        <= 8'h00;
        end else begin
            st_reg        <= st_next;
            freeze_reg    <= freeze_next;
            len_reg       <= len_next;
            ovf_reg       <= ovf_next;
            conn_d_reg    <= modem_connect_in;
            greet_reg     <= greet_next;
            alarm_reg     <= alarm_next;
            rpt_start_reg <= start_next;
            rpt_abort_reg <= abort_next;
            hist_reg      <= hist_next;
            hang_reg      <= hang_next;
            dload_reg     <= dload_next;
            tload_reg     <= tload_next;
            kind_reg      <= kind_next;
            if (start_next) begin
                mod_reg <= mod_next;
            end
            if (dload_next || tload_next) begin
                fa_reg <= f0;
                fb_reg <= f1;
                fc_reg <= f2;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (line_wr) begin
            line_mem[len_reg] <= ch;
        end
    end

    assign tx_out         = tx_line_reg;
    assign rpt_start_out  = rpt_start_reg;
    assign rpt_abort_out  = rpt_abort_reg;
    assign rpt_kind_out   = kind_reg;
    assign rpt_module_out = mod_reg;
    assign hist_reset_out = hist_reg;
    assign hangup_out     = hang_reg;
    assign date_load_out  = dload_reg;
    assign time_load_out  = tload_reg;
    assign date_month_out = fa_reg;
    assign date_day_out   = fb_reg;
    assign date_year_out  = fc_reg;
    assign time_hour_out  = fa_reg;
    assign time_min_out   = fb_reg;
    assign time_sec_out   = fc_reg;
    assign freeze_out     = freeze_reg;
    assign busy_out       = (st_reg == ST_RUN);

    // ---------------- checks ----------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    a_quit_idle: assert property (rx_stb_reg && upcase(ch) == CH_Q // RULE7
        |=> st_reg == ST_IDLE && len_reg == 4'h0)
        else $error("quit did not idle the interpreter");
    a_freeze_toggle: assert property (rx_stb_reg && upcase(ch) == CH_F // RULE5
        |=> freeze_out != $past(freeze_out))
        else $error("freeze key did not toggle");
    a_freeze_stall: assert property (freeze_out && !tx_busy_reg // RULE5
        |=> tx_out)
        else $error("byte started while frozen");
    a_bs_shrink: assert property (rx_stb_reg && ch == CH_BS // RULE14
        && len_reg != 4'h0 |=> len_reg == $past(len_reg) - 4'h1)
        else $error("backspace did not drop a character");
    a_hang_modem: assert property (hangup_out |-> IS_MODEM // RULE10
        && $past(c0, 2) != CH_LO_D)
        else $error("hang-up on a local port");
    a_date_range: assert property (date_load_out |-> date_month_out // RULE8
        != 8'h00 && date_month_out <= BCD_MON && date_day_out <= BCD_DAY)
        else $error("date loaded out of range");
    a_time_range: assert property (time_load_out |-> time_hour_out // RULE9
        <= BCD_HOUR && time_min_out <= BCD_MIN && time_sec_out <= BCD_MIN)
        else $error("time loaded out of range");
    a_start_run: assert property (rpt_start_out |-> busy_out // RULE1
        && rpt_module_out <= 3'h6)
        else $error("report start without run state");
    a_tx_start: assert property (tx_take |=> !tx_out [*2]) // RULE16
        else $error("start bit not driven");
    a_ovf_drop: assert property (rx_stb_reg && ch == CH_CR && ovf_reg // RULE20
        |=> !date_load_out && !time_load_out && !rpt_start_out)
        else $error("overlong line acted on");

    c_event_rpt: cover property (rpt_start_out && rpt_kind_out == RPT_EVENT);
    c_date_set:  cover property (date_load_out);
    c_frozen_full: cover property (freeze_out && !rpt_ready_out);
    c_greeting:  cover property (rpt_start_out && rpt_kind_out == RPT_GREET);
endmodule : tci_interp
`default_nettype wire

// file: design/tci_pkg.sv
// constants shared by the terminal command interpreter
package tci_pkg;
    localparam int          CLK_HZ     = 25_000_000;
    localparam int          BAUD_FAST  = 2400;
    localparam int          BIT_CYC    = CLK_HZ / BAUD_FAST;
    localparam logic [3:0]  LEN_MAX    = 4'hA;
    // received characters
    localparam logic [7:0]  CH_CR      = 8'h0D;
    localparam logic [7:0]  CH_BS      = 8'h08;
    localparam logic [7:0]  CH_DEL     = 8'h7F;
    localparam logic [7:0]  CH_CTLB    = 8'h02;
    localparam logic [7:0]  CH_CTLC    = 8'h03;
    localparam logic [7:0]  CH_SPACE   = 8'h20;
    localparam logic [7:0]  CH_SLASH   = 8'h2F;
    localparam logic [7:0]  CH_COLON   = 8'h3A;
    localparam logic [7:0]  CH_ZERO    = 8'h30;
    localparam logic [7:0]  CH_ONE     = 8'h31;
    localparam logic [7:0]  CH_SIX     = 8'h36;
    localparam logic [7:0]  CH_NINE    = 8'h39;
    localparam logic [7:0]  CH_LO_A    = 8'h61;
    localparam logic [7:0]  CH_LO_Z    = 8'h7A;
    localparam logic [7:0]  CH_LO_D    = 8'h64;
    localparam logic [7:0]  CH_LO_T    = 8'h74;
    localparam logic [7:0]  CH_CASE    = 8'hDF;
    localparam logic [7:0]  CH_A       = 8'h41;
    localparam logic [7:0]  CH_C       = 8'h43;
    localparam logic [7:0]  CH_F       = 8'h46;
    localparam logic [7:0]  CH_G       = 8'h47;
    localparam logic [7:0]  CH_H       = 8'h48;
    localparam logic [7:0]  CH_I       = 8'h49;
    localparam logic [7:0]  CH_J       = 8'h4A;
    localparam logic [7:0]  CH_K       = 8'h4B;
    localparam logic [7:0]  CH_L       = 8'h4C;
    localparam logic [7:0]  CH_M       = 8'h4D;
    localparam logic [7:0]  CH_N       = 8'h4E;
    localparam logic [7:0]  CH_Q       = 8'h51;
    // bcd range limits for clock fields
    localparam logic [7:0]  BCD_MON    = 8'h12;
    localparam logic [7:0]  BCD_DAY    = 8'h31;
    localparam logic [7:0]  BCD_HOUR   = 8'h23;
    localparam logic [7:0]  BCD_MIN    = 8'h59;
    // report kinds handed to the report source
    localparam logic [3:0]  RPT_STATUS = 4'h0;
    localparam logic [3:0]  RPT_EVENT  = 4'h1;
    localparam logic [3:0]  RPT_HIST   = 4'h2;
    localparam logic [3:0]  RPT_BAND0  = 4'h3;
    localparam logic [3:0]  RPT_BAND1  = 4'h4;
    localparam logic [3:0]  RPT_BAND2  = 4'h5;
    localparam logic [3:0]  RPT_BAND3  = 4'h6;
    localparam logic [3:0]  RPT_SUMM   = 4'h7;
    localparam logic [3:0]  RPT_DETAIL = 4'h8;
    localparam logic [3:0]  RPT_GREET  = 4'h9;
    localparam logic [2:0]  MOD_CABINET = 3'h0;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } tci_state_t;
endpackage : tci_pkg

// file: design/tci_skid.sv
// two-entry buffer between report source and serial transmitter
`timescale 1ns/10ps
`default_nettype none
module tci_skid #(
    parameter int W = 8
) (
    input  wire logic         clk_sys_in,
    input  wire logic         rst_in,
    input  wire logic         flush_in,
    input  wire logic [W-1:0] in_data_in,
    input  wire logic         in_valid_in,
    output logic              in_ready_out,
    output logic [W-1:0]      out_data_out,
    output logic              out_valid_out,
    input  wire logic         out_ready_in
);
    logic [W-1:0] mem_reg [2];
    logic         wptr_reg;
    logic         wptr_next;
    logic         rptr_reg;
    logic         rptr_next;
    logic [1:0]   cnt_reg;
    logic [1:0]   cnt_next;
    logic         push;
    logic         pop;

    assign in_ready_out  = (cnt_reg != 2'h2);
    assign out_valid_out = (cnt_reg != 2'h0);
    assign out_data_out  = mem_reg[rptr_reg];
    assign push          = in_valid_in && in_ready_out && !flush_in;
    assign pop           = out_valid_out && out_ready_in && !flush_in;

    always_comb begin
        wptr_next = wptr_reg ^ push;
        rptr_next = rptr_reg ^ pop;
        cnt_next  = cnt_reg + 2'(push) - 2'(pop);
        if (flush_in) begin
            wptr_next = 1'b0;
            rptr_next = 1'b0;
            cnt_next  = 2'h0;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            wptr_reg <= 1'b0;
            rptr_reg <= 1'b0;
            cnt_reg  <= 2'h0;
        end else begin
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
            cnt_reg  <= cnt_next;
        end
    end

    // storage needs no reset; occupancy guards every read
    always_ff @(posedge clk_sys_in) begin
        if (push) begin
            mem_reg[wptr_reg] <= in_data_in;
        end
    end
endmodule : tci_skid
`default_nettype wire

// file: verif/tci_bench.sv
// bench for the command interpreter on a modem port
`timescale 1ns/10ps
`default_nettype none
module tci_interp_bench;
    import tci_pkg::*;
    logic clk_sys_in = 0, rst_in = 1, rx, tx, rdy, vld = 0, done = 0;
    logic slow = 0, con = 0, alm = 0;
    logic st, ab, hr, hu, dl, tl, frz, busy;
    logic [3:0] kind;
    logic [2:0] md;
    logic [7:0] f1, f2, f3, th, tm, ts, dat = 8'hA6;
    int fail_count = 0, checked = 0, cyc = 0, n[6] = '{default: 0};
    initial forever #20 clk_sys_in = ~clk_sys_in;
    tci_term #(.BITC(8)) T (.clk_sys_in(clk_sys_in), .slow_in(slow),
        .line_in(tx), .line_out(rx));
    // date and time share field flops, so both sets are checked against one value
    tci_interp #(.IS_MODEM(1'b1), .BIT_CYCLES(16'h0008)) DUT (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .rx_in(rx),
        .tx_out(tx), .baud_slow_in(slow), .modem_connect_in(con),
        .alarm_new_in(alm), .rpt_data_in(dat), .rpt_valid_in(vld),
        .rpt_ready_out(rdy), .rpt_done_in(done), .rpt_start_out(st),
        .rpt_abort_out(ab), .rpt_kind_out(kind), .rpt_module_out(md),
        .hist_reset_out(hr), .hangup_out(hu), .date_load_out(dl),
        .date_month_out(f1), .date_day_out(f2), .date_year_out(f3),
        .time_load_out(tl), .time_hour_out(th), .time_min_out(tm),
        .time_sec_out(ts), .freeze_out(frz), .busy_out(busy));
    // pulses last one cycle, so they are counted as they pass
    always @(posedge clk_sys_in) begin
        n[0] += int'(st);
        n[1] += int'(ab);
        n[2] += int'(hr);
        n[3] += int'(dl);
        n[4] += int'(tl);
        n[5] += int'(hu);
        if (++cyc == 60000) begin
            fail_count++;
            give_verdict();
        end
    end
    task automatic chk(input string nm, input logic [23:0] s, e);
        checked++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH %s exp %h saw %h", nm, e, s);
        end
    endtask : chk
    task automatic cmd(input string s);
        foreach (s[i]) T.send(s[i]);
        T.send(CH_CR);
        repeat (4) @(negedge clk_sys_in);
    endtask : cmd
    task automatic fin;
        done = 1;
        @(negedge clk_sys_in);
        done = 0;
        @(negedge clk_sys_in);
        chk("busy", busy, 0);
    endtask : fin
    task automatic rpt(string s, logic [3:0] k, logic [2:0] m, bit hold);
        int b;
        b = n[0];
        cmd(s);
        chk("start", 24'(n[0] - b), 1);
        chk("kind", kind, k);
        chk("module", md, m);
        chk("busy", busy, 1);
        if (!hold) fin();
        $display("test %s done", s);
    endtask : rpt
    task automatic ld(string s, int i, int e, logic [23:0] v);
        int b;
        b = n[i];
        cmd(s);
        chk("pulse", 24'(n[i] - b), 24'(e));
        chk("fields", {f1, f2, f3}, v);
        chk("time", {th, tm, ts}, v);
        $display("test %s done", s);
    endtask : ld
    task automatic freeze_fill;
        int k = 0;
        logic [7:0] c;
        rpt("M", RPT_SUMM, MOD_CABINET, 1);
        T.send(8'h66);
        chk("frozen", frz, 1);
        vld = 1;
        repeat (8) begin
            if (rdy === 1'b1) k++;
            @(negedge clk_sys_in);
        end
        chk("accepted", 24'(k), 2);
        chk("tx held", tx, 1);
        fork
            T.send(8'h46);
            T.recv(c);
        join
        chk("tx byte", c, 8'hA6);
        // valid stays up until the waiting word is taken
        while (rdy !== 1'b1) @(negedge clk_sys_in);
        @(negedge clk_sys_in);
        vld = 0;
        repeat (260) @(negedge clk_sys_in);
        chk("unfrozen", {frz, rdy}, 2'b01);
        fin();
        $display("test freeze done");
    endtask : freeze_fill
    task automatic quit;
        int a = n[1], b = n[0];
        rpt("A", RPT_STATUS, MOD_CABINET, 1);
        cmd("I");
        chk("refused", {kind, 20'(n[0] - b)}, 24'h000001);
        T.send(8'h71);
        repeat (4) @(negedge clk_sys_in);
        chk("abort", 24'(n[1] - a), 1);
        chk("idle", busy, 0);
        rpt("A", RPT_STATUS, MOD_CABINET, 0);
    endtask : quit
    task automatic greet;
        int b = n[0];
        con = 1;
        alm = 1;
        repeat (4) @(negedge clk_sys_in);
        alm = 0;
        chk("greet", 24'(n[0] - b), 1);
        chk("kind", kind, RPT_GREET);
        fin();
        chk("no alarm rpt", 24'(n[0] - b), 1);
        $display("test greeting done");
    endtask : greet
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (5) @(negedge clk_sys_in);
        rst_in = 0;
        chk("reset", {tx, rdy, busy, frz}, 4'hC);
        greet();
        rpt("A2", RPT_STATUS, 3'h2, 0);
        rpt("a", RPT_STATUS, MOD_CABINET, 0);
        rpt("\0023", RPT_EVENT, 3'h3, 0);
        rpt("c6", RPT_HIST, 3'h6, 0);
        rpt("I", RPT_BAND0, 3'h0, 0);
        rpt("j", RPT_BAND1, 3'h0, 0);
        slow = 1;
        rpt("K", RPT_BAND2, 3'h0, 0);
        slow = 0;
        rpt("l", RPT_BAND3, 3'h0, 0);
        rpt("n", RPT_DETAIL, 3'h0, 0);
        rpt("A5\0101", RPT_STATUS, 3'h1, 0);
        freeze_fill();
        quit();
        ld("d 12/31/99", 3, 1, 24'h123199);
        ld("t 23:59:58", 4, 1, 24'h235958);
        ld("d 13/01/99", 3, 0, 24'h235958);
        ld("D 01/01/99", 3, 0, 24'h235958);
        ld("d 01/01/99 9", 3, 0, 24'h235958);
        ld("G", 2, 1, 24'h235958);
        ld("H", 5, 1, 24'h235958);
        give_verdict();
    end
endmodule : tci_interp_bench
`default_nettype wire

// file: verif/tci_term.sv
// terminal model: sends 8n1 characters into the port
`timescale 1ns/10ps
`default_nettype none
module tci_term #(
    parameter int BITC = 8
) (
    input  wire logic clk_sys_in,
    input  wire logic slow_in,
    input  wire logic line_in,
    output logic      line_out
);
    initial line_out = 1'b1;
    // start, eight bits lsb first, stop; idle high
    task automatic send(input logic [7:0] ch);
        logic [9:0] f;
        f = {1'b1, ch, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line_out = f[i];
            repeat (slow_in ? 2 * BITC : BITC) @(negedge clk_sys_in);
        end
    endtask : send
    // samples each bit near its middle, lsb first
    task automatic recv(output logic [7:0] c);
        @(negedge line_in);
        repeat (slow_in ? BITC : BITC / 2) @(negedge clk_sys_in);
        for (int i = 0; i < 8; i++) begin
            repeat (slow_in ? 2 * BITC : BITC) @(negedge clk_sys_in);
            c[i] = line_in;
        end
    endtask : recv
endmodule : tci_term
`default_nettype wire
